// ### common/phip_regs.vh
`ifndef PHIP_REGS_VH
`define PHIP_REGS_VH
// ==========================================================
// Host port direct addresses
`define PHIP_HA_POINTER 2'b00
`define PHIP_HA_DATA 2'b01
`define PHIP_HA_FIFO 2'b10
`define PHIP_HA_IRQ 2'b11
// ==========================================================
// Internal indices
`define PHIP_IDX_START 8'h7f
`define PHIP_IDX_LOW_LAST 8'h8f
`define PHIP_IDX_RESULT_FIRST 8'h90
`define PHIP_IDX_RESULT_LAST 8'haf
`define PHIP_IDX_FIFO 8'hb0
`define PHIP_IDX_IRQ_STATUS 8'hc0
`define PHIP_IDX_IRQ_ENABLE 8'hc1
`define PHIP_IDX_PORT_STATUS 8'hc2
`define PHIP_IDX_CRAM 8'hc3
`define PHIP_IDX_MODE_FIRST 8'hd0
`define PHIP_IDX_MODE_LAST 8'hfc
`define PHIP_IDX_FULL_FIELD 8'hfd
// ==========================================================
// Fields
`define PHIP_BIT_CYC_DONE 0
`define PHIP_BIT_FIFO_DATA 1
`define PHIP_BIT_STARTED 1
`define PHIP_BIT_CRAM_OK 2
`define PHIP_MODE_IDLE 8'hff
// ==========================================================
// Timing: low-range latency 64 us at 25 MHz
`define PHIP_LAT_US 64
`define PHIP_CLK_MHZ 25
`define PHIP_LAT_CYC (`PHIP_LAT_US * `PHIP_CLK_MHZ)
// ==========================================================
// Sizes
`define PHIP_RAM_AW 8
`define PHIP_FIFO_DEPTH 16
`endif

// ### hdl/phip_fifo.v
`timescale 1ns/10ps
module phip_fifo #(
  parameter DW = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Fill side
  input wire i_in_valid,
  input wire [DW-1:0] i_in_data,
  output wire o_in_ready,
  // Drain side
  output wire o_out_valid,
  output wire [DW-1:0] o_out_data,
  input wire i_out_ready
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### hdl/phip_host_port.v
`timescale 1ns/10ps
`include "phip_regs.vh"
// Functional notes
// - Write at 00b loads indirect pointer
// - Data port 01b writes/reads pointed register
// - Read at 10b pops next queue byte
// - Address 11b reaches irq status directly
// - Low indices take 64 us, signal done
// - Port status holds cycle-complete bit
// - Enable at C1h raises done interrupt
// - Upper indices finish fast, no interrupt
// - Queue read needs no pointer step
// - Irq status latches sources until cleared
// - Write one clears flag; zero keeps
// - Device idle until index 7Fh written
// - Config RAM port auto-increments location
// - Results via queue B0h or 90h-AFh
// - Config RAM programmed before slicing runs
module phip_host_port (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Host port strobes, one-cycle access pulses
  input wire i_host_rd,
  input wire i_host_wr,
  input wire i_host_sel_hi,
  input wire i_host_sel_lo,
  input wire [7:0] i_host_data,
  output reg [7:0] o_host_data,
  output wire o_host_data_oe_n,
  // Interrupt request, open drain style
  output wire o_int_req_n,
  // Sliced data from the slicer
  input wire i_slice_valid,
  input wire [7:0] i_slice_data,
  output wire o_slice_ready,
  input wire [7:0] i_slice_irq,
  // Result registers written by the slicer
  input wire i_result_we,
  input wire [4:0] i_result_idx,
  input wire [7:0] i_result_data,
  // Slicer control
  output reg o_slicer_run,
  output reg o_cram_open
);
  // ========================================================
  // Decode
  localparam integer LAT_FULL = `PHIP_LAT_CYC;
  localparam [10:0] LAT_CYC = LAT_FULL[10:0];
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_RDONE = 3'b100;

  wire [1:0] ha = {i_host_sel_hi, i_host_sel_lo};
  wire acc = i_host_rd | i_host_wr;

  reg [7:0] ptr_q;
  reg [7:0] irq_q;
  reg [7:0] irq_en_q;
  reg [7:0] low_regs_q [0:15];
  reg [7:0] result_q [0:31];
  reg [7:0] mode_q [0:44];
  reg full_field_q;
  reg started_q;
  reg cram_done_q;
  reg [7:0] cram_loc_q;
  reg [2:0] st_q;
  reg [10:0] lat_q;
  reg cyc_done_q;
  reg [7:0] rd_hold_q;
  reg int_q;
  integer i;
  integer j;

  function is_low;
    input [7:0] idx;
    begin
      // The start index is taken at once, with no latency
      is_low = (idx <= `PHIP_IDX_LOW_LAST) && (idx != `PHIP_IDX_START);
    end
  endfunction

  function in_range;
    input [7:0] idx;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Low registers are modelled as a small bank keyed by the low nibble;
  // the slow internal controller is only represented by its latency.
  wire [3:0] low_sel = ptr_q[3:0];
  wire ptr_wr = i_host_wr && ha == `PHIP_HA_POINTER;
  wire dat_wr = i_host_wr && ha == `PHIP_HA_DATA;
  wire dat_rd = i_host_rd && ha == `PHIP_HA_DATA;
  wire fifo_rd = i_host_rd && ha == `PHIP_HA_FIFO;
  wire irq_wr = i_host_wr && ha == `PHIP_HA_IRQ;
  wire [7:0] wdat = i_host_data;
  wire cram_hit = (ptr_q == `PHIP_IDX_CRAM);
  wire mode_hit = in_range(ptr_q, `PHIP_IDX_MODE_FIRST, `PHIP_IDX_MODE_LAST);
  wire [5:0] mode_sel = ptr_q[5:0] - 6'h10;
  wire [7:0] res_off = ptr_q - `PHIP_IDX_RESULT_FIRST;

  // ========================================================
  // Queue and config RAM
  wire q_valid;
  wire [7:0] q_data;
  wire q_pop = fifo_rd | (dat_rd && ptr_q == `PHIP_IDX_FIFO);
  wire [7:0] ram_rdata;
  wire ram_we = dat_wr && cram_hit && o_cram_open;

  phip_fifo #(
    .DW(8),
    .DEPTH(`PHIP_FIFO_DEPTH),
    .AW(4)
  ) u_queue (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_slice_valid && started_q),
    .i_in_data(i_slice_data),
    .o_in_ready(o_slice_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_data),
    .i_out_ready(q_pop)
  );

  phip_ram #(
    .AW(`PHIP_RAM_AW),
    .DW(8)
  ) u_cram (
    .i_clk_sys(i_clk_sys),
    .i_we(ram_we),
    .i_addr(cram_loc_q),
    .i_wdata(wdat),
    .o_rdata(ram_rdata)
  );

  // ========================================================
  // Config RAM writes and location steps happen only with all line modes idle and
  // full field off, so the slicer never fights the host for it.
  reg all_idle;
  always @* begin
    all_idle = ~full_field_q;
    for (j = 0; j < 45; j = j + 1) begin
      all_idle = all_idle & (mode_q[j] == `PHIP_MODE_IDLE);
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cram_open <= 1'b0;
      o_slicer_run <= 1'b0;
    end else begin
      o_cram_open <= all_idle;
      o_slicer_run <= started_q && cram_done_q && !all_idle;
    end
  end

  // ========================================================
  // Pointer, start, registers
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_q <= 8'h00;
      started_q <= 1'b0;
      irq_en_q <= 8'h00;
      full_field_q <= 1'b0;
      cram_loc_q <= 8'h00;
      cram_done_q <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        low_regs_q[i] <= 8'h00;
      end
      for (i = 0; i < 45; i = i + 1) begin
        mode_q[i] <= `PHIP_MODE_IDLE;
      end
    end else begin
      if (ptr_wr) begin
        ptr_q <= wdat;
      end
      if (dat_wr) begin
        if (ptr_q == `PHIP_IDX_START) begin
          started_q <= 1'b1;
        end else if (is_low(ptr_q)) begin
          low_regs_q[low_sel] <= wdat;
        end
        if (ptr_q == `PHIP_IDX_IRQ_ENABLE) begin
          irq_en_q <= wdat;
        end
        if (ptr_q == `PHIP_IDX_FULL_FIELD) begin
          full_field_q <= wdat[0];
        end
        if (mode_hit) begin
          mode_q[mode_sel] <= wdat;
        end
      end
      if ((dat_wr || dat_rd) && cram_hit && o_cram_open) begin
        cram_loc_q <= cram_loc_q + 8'h01;
        if (dat_wr && cram_loc_q == 8'hff) begin
          cram_done_q <= 1'b1;
        end
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_result_we) begin
      result_q[i_result_idx] <= i_result_data;
    end
  end

  // ========================================================
  // Low-range latency engine: starts on pointer write for
  // reads and on data write for writes; host must wait.
  wire low_rd_start = ptr_wr && is_low(wdat);
  wire low_wr_start = dat_wr && is_low(ptr_q);

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      lat_q <= 11'h000;
      cyc_done_q <= 1'b1;
      rd_hold_q <= 8'h00;
    end else begin
      case (st_q)
        // Completion cycle takes a new access too, so a host that
        // starts right after seeing cycle-complete is not dropped.
        ST_IDLE, ST_RDONE: begin
          if (low_rd_start || low_wr_start) begin
            st_q <= ST_BUSY;
            lat_q <= LAT_CYC - 11'h001;
            cyc_done_q <= 1'b0;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (lat_q == 11'h000) begin
            st_q <= ST_RDONE;
            cyc_done_q <= 1'b1;
            rd_hold_q <= low_regs_q[low_sel];
          end else begin
            lat_q <= lat_q - 11'h001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  wire done_evt = (st_q == ST_BUSY) && (lat_q == 11'h000);

  // ========================================================
  // Interrupt status: set wins over write-one clear
  wire [7:0] set_v = i_slice_irq |
    {7'h00, done_evt && irq_en_q[`PHIP_BIT_CYC_DONE]};
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      irq_q <= (irq_q & ~(irq_wr ? wdat : 8'h00)) | set_v;
      int_q <= |irq_q;
    end
  end
  assign o_int_req_n = ~int_q;

  // ========================================================
  // Read mux, data registered for the read strobe cycle
  reg [7:0] rd_v;
  always @* begin
    rd_v = 8'h00;
    case (ha)
      `PHIP_HA_DATA: begin
        if (is_low(ptr_q)) begin
          rd_v = rd_hold_q;
        end else if (in_range(ptr_q, `PHIP_IDX_RESULT_FIRST,
                              `PHIP_IDX_RESULT_LAST)) begin
          rd_v = result_q[res_off[4:0]];
        end else if (ptr_q == `PHIP_IDX_FIFO) begin
          rd_v = q_valid ? q_data : 8'h00;
        end else if (ptr_q == `PHIP_IDX_IRQ_STATUS) begin
          rd_v = irq_q;
        end else if (ptr_q == `PHIP_IDX_IRQ_ENABLE) begin
          rd_v = irq_en_q;
        end else if (ptr_q == `PHIP_IDX_PORT_STATUS) begin
          rd_v = {5'h00, cram_done_q, started_q, cyc_done_q};
        end else if (cram_hit) begin
          rd_v = ram_rdata;
        end else if (mode_hit) begin
          rd_v = mode_q[mode_sel];
        end else if (ptr_q == `PHIP_IDX_FULL_FIELD) begin
          rd_v = {7'h00, full_field_q};
        end
      end
      `PHIP_HA_FIFO: begin
        rd_v = q_valid ? q_data : 8'h00;
      end
      `PHIP_HA_IRQ: begin
        rd_v = irq_q;
      end
      default: begin
        rd_v = 8'h00;
      end
    endcase
  end

  reg drive_q;
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_host_data <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      drive_q <= i_host_rd;
      if (i_host_rd) begin
        o_host_data <= rd_v;
      end
    end
  end
  assign o_host_data_oe_n = ~drive_q;
endmodule

// ### hdl/phip_ram.v
`timescale 1ns/10ps
`include "phip_regs.vh"
module phip_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock
  input wire i_clk_sys,
  // Write port
  input wire i_we,
  input wire [AW-1:0] i_addr,
  input wire [DW-1:0] i_wdata,
  // Registered read data
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

// ### tb/phip_host_model.sv
`timescale 1ns/10ps
// ======
// Host controller model, one strobe cycle per access
module phip_host_model (
  input wire i_clk_sys,
  input wire [7:0] i_rdata,
  output reg o_rd,
  output reg o_wr,
  output reg [1:0] o_addr,
  output reg [7:0] o_data
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 2'b00;
    o_data = 8'h00;
  end
  // Released lines carry the inverse so stale values never match
  task xfer(input w, input [1:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge i_clk_sys) #1;
      o_wr = w;
      o_rd = ~w;
      o_addr = a;
      o_data = d;
      @(posedge i_clk_sys) #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_data = ~d;
      q = i_rdata;
    end
  endtask
endmodule

// ### tb/phip_host_port_assertions.sv
`timescale 1ns/10ps
// ======
// Port checker
module phip_host_port_chk (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Host side
  input wire i_host_rd,
  input wire i_host_wr,
  input wire i_host_sel_hi,
  input wire i_host_sel_lo,
  input wire [7:0] i_host_data,
  input wire [7:0] o_host_data,
  input wire o_host_data_oe_n,
  input wire o_int_req_n,
  // Slicer side
  input wire i_slice_valid,
  input wire o_slice_ready,
  input wire [7:0] i_slice_irq,
  input wire o_slicer_run,
  input wire o_cram_open
);
  reg [7:0] ptr_q;
  reg st_q;
  reg en_q;
  reg [10:0] bc_q;
  reg [4:0] cnt_q;
  wire [1:0] ha = {i_host_sel_hi, i_host_sel_lo};
  wire pw = i_host_wr && ha == 2'b00;
  wire dw = i_host_wr && ha == 2'b01;
  wire lo_p = pw && i_host_data <= 8'h8f && i_host_data != 8'h7f;
  wire lo_d = dw && ptr_q <= 8'h8f && ptr_q != 8'h7f;
  wire push = i_slice_valid && o_slice_ready && st_q;
  wire pop = i_host_rd && cnt_q != 5'h00 &&
    (ha == 2'b10 || (ha == 2'b01 && ptr_q == 8'hb0));
  // Mirrors the 1600-cycle busy window of a low-range access
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_q <= 8'h00;
      st_q <= 1'b0;
      en_q <= 1'b0;
      bc_q <= 11'h000;
      cnt_q <= 5'h00;
    end else begin
      if (pw)
        ptr_q <= i_host_data;
      if (dw && ptr_q == 8'h7f)
        st_q <= 1'b1;
      if (dw && ptr_q == 8'hc1)
        en_q <= i_host_data[0];
      if (bc_q != 11'h000)
        bc_q <= bc_q - 11'h001;
      else if (lo_p || lo_d)
        bc_q <= 11'h640;
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  rd_drive_a: assert property (i_host_rd |=> !o_host_data_oe_n)
    else $error("read data not driven");
  oe_pulse_a: assert property (!o_host_data_oe_n |-> $past(i_host_rd))
    else $error("data driven without read");
  fifo_empty_a: assert property (
    i_host_rd && ha == 2'b10 && cnt_q == 5'h00 |=> o_host_data == 8'h00)
    else $error("empty queue read not zero");
  fifo_full_a: assert property (cnt_q == 5'h10 |-> !o_slice_ready)
    else $error("full queue still ready");
  done_irq_a: assert property (
    bc_q == 11'h001 && en_q |-> ##2 !o_int_req_n)
    else $error("no completion interrupt");
  irq_latch_a: assert property (i_slice_irq != 8'h00 |-> ##2 !o_int_req_n)
    else $error("source not latched");
  irq_hold_a: assert property (
    !o_int_req_n && !i_host_wr && !$past(i_host_wr) |=> !o_int_req_n)
    else $error("interrupt dropped uncleared");
  irq_clear_a: assert property (
    (i_host_wr && ha == 2'b11 && i_host_data == 8'hff && bc_q == 11'h000
    && i_slice_irq == 8'h00) ##1 (i_slice_irq == 8'h00) |-> ##2 o_int_req_n)
    else $error("clear left interrupt");
  run_start_a: assert property (o_slicer_run |-> st_q)
    else $error("ran before start");
  run_excl_a: assert property (o_cram_open |-> !o_slicer_run)
    else $error("ram open while running");
endmodule

bind phip_host_port phip_host_port_chk u_chk (
  .i_clk_sys, .i_sys_rst, .i_host_rd, .i_host_wr, .i_host_sel_hi,
  .i_host_sel_lo, .i_host_data, .o_host_data, .o_host_data_oe_n,
  .o_int_req_n, .i_slice_valid, .o_slice_ready, .i_slice_irq,
  .o_slicer_run, .o_cram_open
);

// ### tb/phip_host_port_tb.sv
`timescale 1ns/10ps
// ======
// Bench
module phip_host_port_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg valid = 1'b0;
  reg rwe = 1'b0;
  reg [4:0] ridx = 5'h00;
  reg [7:0] sdata = 8'h00;
  reg [7:0] sirq = 8'h00;
  reg [7:0] rdat = 8'h00;
  wire rd, wr, oe_n, irq_n, ready, run, copen;
  wire [1:0] ad;
  wire [7:0] hw;
  wire [7:0] hd;
  integer mismatches = 0;
  integer checked = 0;
  integer cyc = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  phip_host_port uut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_host_rd(rd), .i_host_wr(wr),
    .i_host_sel_hi(ad[1]), .i_host_sel_lo(ad[0]), .i_host_data(hw),
    .o_host_data(hd), .o_host_data_oe_n(oe_n), .o_int_req_n(irq_n),
    .i_slice_valid(valid), .i_slice_data(sdata), .o_slice_ready(ready),
    .i_slice_irq(sirq), .i_result_we(rwe), .i_result_idx(ridx),
    .i_result_data(rdat), .o_slicer_run(run), .o_cram_open(copen));
  phip_host_model host (.i_clk_sys(clk), .i_rdata(hd), .o_rd(rd),
    .o_wr(wr), .o_addr(ad), .o_data(hw));
  // ======
  // Shared tasks
  task chk(input string n, input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task close_out;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task wh(input [1:0] a, input [7:0] d);
    reg [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task rh(input [1:0] a, output [7:0] q);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  task iw(input [7:0] i, input [7:0] d);
    begin
      wh(2'b00, i);
      wh(2'b01, d);
    end
  endtask
  task ir(input [7:0] i, output [7:0] q);
    begin
      wh(2'b00, i);
      rh(2'b01, q);
    end
  endtask
  // Host waits out the latency on the interrupt pin
  task wait_irq(input integer t0);
    integer k;
    begin
      k = 0;
      while (irq_n !== 1'b0 && k < 3000) begin
        @(posedge clk) #1;
        k = k + 1;
      end
      if (k >= 3000) begin
        mismatches = mismatches + 1;
        close_out;
      end else begin
        chk("latency", (cyc - t0) inside {[1599:1606]}, 1'b1);
      end
    end
  endtask
  // ======
  // Scenarios
  task s_start;
    reg [7:0] q;
    begin
      @(posedge clk) #1;
      chk("open", copen, 1'b1);
      chk("run", run, 1'b0);
      iw(8'h7f, 8'h3c);
      ir(8'hc2, q);
      chk("status", q[2:0], 3'b011);
    end
  endtask
  task s_low;
    reg [7:0] q;
    integer t0;
    begin
      iw(8'hc1, 8'h01);
      wh(2'b00, 8'h05);
      t0 = cyc;
      wait_irq(t0);
      rh(2'b11, q);
      chk("done_flag", q[0], 1'b1);
      wh(2'b11, 8'h01);
      repeat (4) @(posedge clk);
      wh(2'b01, 8'ha5);
      t0 = cyc;
      ir(8'hc2, q);
      chk("busy", q[0], 1'b0);
      wait_irq(t0);
      rh(2'b01, q);
      chk("complete", q[0], 1'b1);
      wh(2'b11, 8'h01);
      repeat (4) @(posedge clk);
      wh(2'b00, 8'h05);
      t0 = cyc;
      wait_irq(t0);
      wh(2'b11, 8'h01);
      rh(2'b01, q);
      chk("low_data", q, 8'ha5);
    end
  endtask
  task s_upper;
    reg [7:0] q;
    begin
      @(posedge clk) #1;
      rwe = 1'b1;
      ridx = 5'h03;
      rdat = 8'h3c;
      @(posedge clk) #1;
      rwe = 1'b0;
      ir(8'h93, q);
      chk("result", q, 8'h3c);
      rh(2'b01, q);
      chk("result_again", q, 8'h3c);
      ir(8'hc2, q);
      chk("upper_done", q[0], 1'b1);
      chk("no_irq", irq_n, 1'b1);
    end
  endtask
  task s_fifo;
    reg [7:0] q;
    reg ok;
    integer n, i;
    begin
      n = 0;
      valid = 1'b1;
      for (i = 0; i < 20; i = i + 1) begin
        sdata = 8'h40 + n[7:0];
        ok = ready;
        @(posedge clk) #1;
        if (ok)
          n = n + 1;
      end
      valid = 1'b0;
      chk("fill", n[7:0], 8'h10);
      for (i = 0; i < 16; i = i + 1) begin
        rh(2'b10, q);
        chk("pop", q, 8'h40 + i[7:0]);
      end
      rh(2'b10, q);
      chk("empty", q, 8'h00);
      valid = 1'b1;
      sdata = 8'h77;
      @(posedge clk) #1;
      valid = 1'b0;
      ir(8'hb0, q);
      chk("queue_idx", q, 8'h77);
    end
  endtask
  task s_irq;
    reg [7:0] q;
    begin
      sirq = 8'h82;
      @(posedge clk) #1;
      sirq = 8'h00;
      repeat (2) @(posedge clk) #1;
      chk("irq_pin", irq_n, 1'b0);
      rh(2'b11, q);
      chk("irq_src", q, 8'h82);
      wh(2'b11, 8'h02);
      rh(2'b11, q);
      chk("irq_keep", q, 8'h80);
      wh(2'b11, 8'hff);
      rh(2'b11, q);
      chk("irq_clear", q, 8'h00);
      chk("irq_pin", irq_n, 1'b1);
    end
  endtask
  task s_cram;
    reg [7:0] q;
    integer i;
    begin
      wh(2'b00, 8'hc3);
      for (i = 0; i < 256; i = i + 1)
        wh(2'b01, i[7:0] ^ 8'h5a);
      ir(8'hc2, q);
      chk("cram_done", q[2], 1'b1);
      chk("run_idle", run, 1'b0);
      ir(8'hc3, q);
      chk("cram_rd0", q, 8'h5a);
      rh(2'b01, q);
      chk("cram_rd1", q, 8'h5b);
      iw(8'hd0, 8'h03);
      @(posedge clk) #1;
      chk("run", run, 1'b1);
      chk("open", copen, 1'b0);
      iw(8'hc3, 8'h00);
      iw(8'hd0, 8'hff);
      ir(8'hc3, q);
      chk("cram_rd2", q, 8'h58);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    s_start;
    s_low;
    s_upper;
    s_fifo;
    s_irq;
    s_cram;
    close_out;
  end
endmodule
